/* File: core/dbg_cmp_defines.svh */
// Register indices, field positions and reset values of the debug bus comparator
`ifndef DBG_CMP_DEFINES_SVH
`define DBG_CMP_DEFINES_SVH

`define IDX_CONTROL      8'h20
`define IDX_SELECT       8'h21
`define IDX_STATUS       8'h22
`define IDX_ADDR_LOW     8'h2b
`define IDX_DATA_HIGH    8'h2c
`define IDX_DATA_LOW     8'h2d
`define IDX_DATA_HI_MASK 8'h2e
`define IDX_DATA_LO_MASK 8'h2f

`define CTRL_ARM_BIT     0
`define CMP_COUNT        4
`define CMP_A            2'd0
`define CMP_B            2'd1
`define CMP_C            2'd2

`define RST_BYTE         8'h00
`define RST_SEL          2'h0
`define RST_MATCH        4'h0
`define ZERO_WORD        32'h0000_0000
`define ALL_ONES_BYTE    8'hff

`endif

/* File: core/dbg_cmp_pkg.sv */
// Types shared by the debug bus comparator files
package dbg_cmp_pkg;
    typedef logic [7:0]  reg_index_t;
    typedef logic [31:0] bus_word_t;
    typedef logic [7:0]  cfg_byte_t;
    typedef logic [1:0]  cmp_sel_t;
    typedef logic [15:0] proc_word_t;
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_t;
endpackage

/* File: core/cmp_cfg_if.sv */
// Configuration and match carrier between register file and one comparator
interface cmp_cfg_if;
    import dbg_cmp_pkg::*;
    cfg_byte_t  addr_low;
    cfg_byte_t  data_high;
    cfg_byte_t  data_low;
    cfg_byte_t  data_high_mask;
    cfg_byte_t  data_low_mask;
    logic       has_data;
    cfg_byte_t  proc_addr;
    proc_word_t proc_data;
    logic       proc_valid;
    logic       match;

    modport ctrl (
        output addr_low, data_high, data_low, data_high_mask, data_low_mask,
        output has_data, proc_addr, proc_data, proc_valid,
        input  match
    );
    modport unit (
        input  addr_low, data_high, data_low, data_high_mask, data_low_mask,
        input  has_data, proc_addr, proc_data, proc_valid,
        output match
    );
endinterface

/* File: core/cmp_unit.sv */
// One bus comparator: address low check plus masked data check
`include "dbg_cmp_defines.svh"

module cmp_unit (
    cmp_cfg_if.unit cfg
);
    import dbg_cmp_pkg::*;

    logic addr_ok;
    logic high_ok;
    logic low_ok;
    logic data_ok;

    // Stored 1 expects a one, stored 0 expects a zero
    assign addr_ok = (cfg.proc_addr == cfg.addr_low);
    // Only bits whose mask bit is 1 take part
    assign high_ok = (((cfg.proc_data[15:8] ^ cfg.data_high)
                      & cfg.data_high_mask) == `RST_BYTE);
    assign low_ok  = (((cfg.proc_data[7:0] ^ cfg.data_low)
                      & cfg.data_low_mask) == `RST_BYTE);
    // Address only comparators skip the data check
    assign data_ok = !cfg.has_data || (high_ok && low_ok);
    assign cfg.match = cfg.proc_valid && addr_ok && data_ok;
endmodule

/* File: core/debug_bus_comparator.sv */
// Debug bus comparator: Avalon-MM register file, four comparators, match outputs
`include "dbg_cmp_defines.svh"

module debug_bus_comparator (
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    input  wire dbg_cmp_pkg::reg_index_t avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire dbg_cmp_pkg::bus_word_t  avs_writedata_in,
    output      dbg_cmp_pkg::bus_word_t  avs_readdata_out,
    output      logic                   avs_waitrequest_out,
    input  wire dbg_cmp_pkg::cfg_byte_t  proc_addr_in,
    input  wire dbg_cmp_pkg::proc_word_t proc_data_in,
    input  wire logic                   proc_valid_in,
    output      logic [3:0]             match_out,
    output      logic                   armed_out
);
    import dbg_cmp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    bus_state_t state_reg;
    logic       waitrequest_reg;
    bus_word_t  readdata_reg;
    bus_word_t  readdata_next;
    logic       armed_reg;
    cmp_sel_t   sel_reg;
    logic [3:0] match_reg;
    logic [3:0] match_next;
    cfg_byte_t  addr_low_reg  [`CMP_COUNT];
    cfg_byte_t  data_high_reg [`CMP_COUNT];
    cfg_byte_t  data_low_reg  [`CMP_COUNT];
    cfg_byte_t  dh_mask_reg   [`CMP_COUNT];
    cfg_byte_t  dl_mask_reg   [`CMP_COUNT];
    logic       accept_wr;
    logic       sel_has_data;

    assign accept_wr    = (state_reg == BUS_ACK) && avs_write_in;
    assign sel_has_data = (sel_reg == `CMP_A) || (sel_reg == `CMP_C);

    ////////////////////////////////////////////////////////////////////////////
    // Avalon slave handshake: one wait cycle, answer on the second edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg       <= BUS_IDLE;
            waitrequest_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                BUS_IDLE: begin
                    if (avs_read_in || avs_write_in) begin
                        state_reg       <= BUS_ACK;
                        waitrequest_reg <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    state_reg       <= BUS_IDLE;
                    waitrequest_reg <= 1'b1;
                end
            endcase
        end
    end

    // Read mux, unmapped and absent registers read zero
    always_comb begin
        readdata_next = `ZERO_WORD;
        unique case (avs_address_in)
            `IDX_CONTROL:  readdata_next[`CTRL_ARM_BIT] = armed_reg;
            `IDX_SELECT:   readdata_next[1:0] = sel_reg;
            `IDX_STATUS:   readdata_next[3:0] = match_reg;
            `IDX_ADDR_LOW: readdata_next[7:0] = addr_low_reg[sel_reg];
            `IDX_DATA_HIGH:
                readdata_next[7:0] = sel_has_data ? data_high_reg[sel_reg] : `RST_BYTE;
            `IDX_DATA_LOW:
                readdata_next[7:0] = sel_has_data ? data_low_reg[sel_reg] : `RST_BYTE;
            `IDX_DATA_HI_MASK:
                readdata_next[7:0] = sel_has_data ? dh_mask_reg[sel_reg] : `RST_BYTE;
            `IDX_DATA_LO_MASK:
                readdata_next[7:0] = sel_has_data ? dl_mask_reg[sel_reg] : `RST_BYTE;
            default:       readdata_next = `ZERO_WORD;
        endcase
    end

    // Read data sampled while waiting, held through the answer edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            readdata_reg <= `ZERO_WORD;
        end else if (state_reg == BUS_IDLE && avs_read_in) begin
            readdata_reg <= readdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and select registers, writable at any time
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            armed_reg <= 1'b0;
            sel_reg   <= `RST_SEL;
        end else if (accept_wr) begin
            if (avs_address_in == `IDX_CONTROL) begin
                armed_reg <= avs_writedata_in[`CTRL_ARM_BIT];
            end
            if (avs_address_in == `IDX_SELECT) begin
                sel_reg <= avs_writedata_in[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per comparator configuration, write path and match unit
    genvar i;
    generate
        for (i = 0; i < `CMP_COUNT; i++) begin : g_cmp
            localparam logic HAS_DATA = (i == 0) || (i == 2);
            logic wr_hit;
            cmp_cfg_if cfg ();

            assign wr_hit = accept_wr && !armed_reg && (sel_reg == cmp_sel_t'(i));

            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    addr_low_reg[i] <= `RST_BYTE;
                end else if (wr_hit && avs_address_in == `IDX_ADDR_LOW) begin
                    addr_low_reg[i] <= avs_writedata_in[7:0];
                end
            end

            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    data_high_reg[i] <= `RST_BYTE;
                    data_low_reg[i]  <= `RST_BYTE;
                    dh_mask_reg[i]   <= `RST_BYTE;
                    dl_mask_reg[i]   <= `RST_BYTE;
                end else if (wr_hit && HAS_DATA) begin
                    unique case (avs_address_in)
                        `IDX_DATA_HIGH:    data_high_reg[i] <= avs_writedata_in[7:0];
                        `IDX_DATA_LOW:     data_low_reg[i]  <= avs_writedata_in[7:0];
                        `IDX_DATA_HI_MASK: dh_mask_reg[i]   <= avs_writedata_in[7:0];
                        `IDX_DATA_LO_MASK: dl_mask_reg[i]   <= avs_writedata_in[7:0];
                        default: ;
                    endcase
                end
            end

            assign cfg.addr_low       = addr_low_reg[i];
            assign cfg.data_high      = data_high_reg[i];
            assign cfg.data_low       = data_low_reg[i];
            assign cfg.data_high_mask = dh_mask_reg[i];
            assign cfg.data_low_mask  = dl_mask_reg[i];
            assign cfg.has_data       = HAS_DATA;
            assign cfg.proc_addr      = proc_addr_in;
            assign cfg.proc_data      = proc_data_in;
            assign cfg.proc_valid     = proc_valid_in;
            assign match_next[i]      = cfg.match;

            cmp_unit u_unit (
                .cfg (cfg.unit)
            );
        end
    endgenerate

    // Match flags registered on every clock edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            match_reg <= `RST_MATCH;
        end else begin
            match_reg <= match_next;
        end
    end

    assign avs_readdata_out    = readdata_reg;
    assign avs_waitrequest_out = waitrequest_reg;
    assign match_out           = match_reg;
    assign armed_out           = armed_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic a_addr_ok;
    assign a_addr_ok = (proc_addr_in == addr_low_reg[0]);

    property p_mask_high_off;
        proc_valid_in && a_addr_ok && dh_mask_reg[0] == `RST_BYTE
            && dl_mask_reg[0] == `RST_BYTE |=> match_reg[0];
    endproperty
    a_mask_high_off: assert property (p_mask_high_off) else $error("mask 0 bit compared");

    property p_armed_block;
        accept_wr && armed_reg && avs_address_in == `IDX_ADDR_LOW
            |=> addr_low_reg[$past(sel_reg)] == $past(addr_low_reg[sel_reg]);
    endproperty
    a_armed_block: assert property (p_armed_block) else $error("write taken while armed");

    property p_addr_miss;
        proc_valid_in && !a_addr_ok |=> !match_reg[0];
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("match despite address");

    property p_high_miss;
        proc_valid_in && ((proc_data_in[15:8] ^ data_high_reg[0]) & dh_mask_reg[0]) != 8'h00
            |=> !match_reg[0];
    endproperty
    a_high_miss: assert property (p_high_miss) else $error("match despite data high");

    property p_low_miss;
        proc_valid_in && ((proc_data_in[7:0] ^ data_low_reg[2]) & dl_mask_reg[2]) != 8'h00
            |=> !match_reg[2];
    endproperty
    a_low_miss: assert property (p_low_miss) else $error("masked low bit ignored");

    property p_addr_only;
        proc_valid_in && proc_addr_in == addr_low_reg[1] |=> match_reg[1];
    endproperty
    a_addr_only: assert property (p_addr_only) else $error("comparator B checked data");

    property p_low_hit;
        proc_valid_in && a_addr_ok && dh_mask_reg[0] == `RST_BYTE
            && dl_mask_reg[0] == `ALL_ONES_BYTE && proc_data_in[7:0] == data_low_reg[0]
            |=> match_reg[0];
    endproperty
    a_low_hit: assert property (p_low_hit) else $error("data low hit missed");

    property p_idle_no_match;
        !proc_valid_in |=> match_reg == 4'h0;
    endproperty
    a_idle_no_match: assert property (p_idle_no_match) else $error("match without cycle");

    property p_answer;
        (avs_read_in || avs_write_in) && state_reg == BUS_IDLE |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");

    c_match_a:   cover property (match_reg[0]);
    c_match_b:   cover property (match_reg[1]);
    c_blocked:   cover property (accept_wr && armed_reg && avs_address_in == `IDX_DATA_HIGH);
    c_read_done: cover property (avs_read_in && !avs_waitrequest_out);
endmodule

/* File: tb/proc_bus_model.sv */
// Model of the monitored processor address and data buses
module proc_bus_model (
    input  wire logic                   clk_in,
    output      dbg_cmp_pkg::cfg_byte_t  addr_out,
    output      dbg_cmp_pkg::proc_word_t data_out,
    output      logic                   valid_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import dbg_cmp_pkg::*;

    initial begin
        addr_out = 8'h00;
        data_out = 16'h0000;
        valid_out = 1'b0;
    end

    // One bus cycle; an idle bus shows the inverse of its last value
    task automatic cycle(input cfg_byte_t a, input proc_word_t d, input logic v);
        @(posedge clk_in);
        valid_out <= v;
        addr_out <= v ? a : ~addr_out;
        data_out <= v ? d : ~data_out;
    endtask
endmodule

/* File: tb/tb_debug_bus_comparator.sv */
// Self-checking bench of the debug bus comparator
module tb_debug_bus_comparator;
    timeunit 1ns;
    timeprecision 1ps;
    import dbg_cmp_pkg::*;
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
$display("Error %s expected %h seen %h", nm, ex, got); end end

    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    reg_index_t avs_address = 8'h00;
    logic       avs_read = 1'b0;
    logic       avs_write = 1'b0;
    bus_word_t  avs_writedata = 32'h0000_0000;
    bus_word_t  avs_readdata;
    logic       avs_waitrequest;
    cfg_byte_t  proc_addr;
    proc_word_t proc_data;
    logic       proc_valid;
    logic [3:0] match;
    logic       armed;
    int         error_cnt = 0;
    int         samples_checked = 0;
    logic [31:0] seed = 32'd77098;
    cfg_byte_t  cfg [4][5];

    always #10 clk_in = ~clk_in;

    debug_bus_comparator DUT (
        .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
        .proc_addr_in(proc_addr), .proc_data_in(proc_data), .proc_valid_in(proc_valid),
        .match_out(match), .armed_out(armed)
    );
    proc_bus_model partner (
        .clk_in(clk_in), .addr_out(proc_addr), .data_out(proc_data), .valid_out(proc_valid)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected match of all four comparators; B and D hold zero masks
    function automatic logic [3:0] exp_match(cfg_byte_t a, proc_word_t d, logic v);
        logic [3:0] m;
        for (int i = 0; i < 4; i++) begin
            m[i] = v && a == cfg[i][0] &&
                   (((d ^ {cfg[i][1], cfg[i][2]}) & {cfg[i][3], cfg[i][4]}) == 16'h0000);
        end
        return m;
    endfunction

    task automatic finish_test();
        $display("Checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic bus_op(input logic wr, input reg_index_t a, input cfg_byte_t wd,
                          output bus_word_t rd);
        int n;
        @(posedge clk_in);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h000000, wd};
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) begin
            error_cnt++;
            finish_test();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input reg_index_t a, input cfg_byte_t d);
        bus_word_t r;
        bus_op(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input reg_index_t a, input cfg_byte_t ex);
        bus_word_t r;
        bus_op(1'b0, a, 8'h00, r);
        `CHK("readdata", {24'h000000, ex}, r)
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int k;
        logic vld;
        cfg_byte_t v;
        proc_word_t d;
        logic [3:0] prev;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        for (i = 8'h2b; i <= 8'h2f; i++) rd_chk(8'(i), 8'h00);
        // Program every comparator at random
        for (k = 0; k < 4; k++) begin
            wr(8'h21, 8'(k));
            for (i = 0; i < 5; i++) begin
                v = 8'(rnd());
                wr(8'(8'h2b + i), v);
                cfg[k][i] = (i == 0 || k % 2 == 0) ? v : 8'h00;
                rd_chk(8'(8'h2b + i), cfg[k][i]);
            end
        end
        // Armed: comparator configuration writes dropped, control writes and all reads still answered
        wr(8'h21, 8'h00);
        wr(8'h20, 8'h01);
        @(posedge clk_in);
        `CHK("armed", 1'b1, armed)
        rd_chk(8'h20, 8'h01);
        rd_chk(8'h21, 8'h00);
        for (i = 0; i < 5; i++) wr(8'(8'h2b + i), ~cfg[0][i]);
        for (i = 0; i < 5; i++) rd_chk(8'(8'h2b + i), cfg[0][i]);
        wr(8'h20, 8'h00);
        rd_chk(8'h20, 8'h00);
        wr(8'h10, 8'hff);
        rd_chk(8'h10, 8'h00);
        // Back-to-back compares, mask 0 bits flipped freely
        prev = 4'h0;
        for (i = 0; i < 400; i++) begin
            k = rnd() % 4;
            vld = rnd() % 5 != 0;
            v = (rnd() % 4 == 0) ? 8'(rnd()) : cfg[k][0];
            d = {cfg[k][1], cfg[k][2]} ^ ((rnd() % 3 == 0) ? 16'(rnd()) :
                (16'(rnd()) & ~{cfg[k][3], cfg[k][4]}));
            partner.cycle(v, d, vld);
            #1;
            `CHK("match", prev, match)
            prev = exp_match(v, d, vld);
        end
        // Bus frozen after the last cycle: status shows the last match
        rd_chk(8'h22, {4'h0, prev});
        `CHK("match", prev, match)
        finish_test();
    end
endmodule
